//--- verilog/scmwm_top.sv
// serial code memory write/modify sequencer with apb status access
// assumes the programmer drives PROG_CLK_I and PROG_DAT_I as one domain
`timescale 1ns/1ns
`default_nettype none
module scmwm_top
    import scmwm_pkg::*;
#(
    parameter int ROW_BYTES = 64,
    parameter int MEM_BYTES = 1024,
    parameter int PROG_HOLD_CYC = PROG_HOLD_CYC_DFLT
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic PROG_CLK_I,
    input wire logic PROG_DAT_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O
);
    localparam int RW = $clog2(ROW_BYTES);
    localparam int MW = $clog2(MEM_BYTES);

    scmwm_link_if lnk ();

    scmwm_link_rx u_link (
        .prog_clk_i(PROG_CLK_I),
        .rst_n_i(RST_N_I),
        .prog_dat_i(PROG_DAT_I),
        .lnk(lnk.link_side)
    );

    // crossings: toggles two flops then edge detect, link clock level two flops
    logic wt_s1_r;
    logic wt_s2_r;
    logic wt_s3_r;
    logic et_s1_r;
    logic et_s2_r;
    logic et_s3_r;
    logic ck_s1_r;
    logic ck_s2_r;

    always_ff @(posedge SYS_CLK_I) begin
        wt_s1_r <= lnk.word_tgl;
        wt_s2_r <= wt_s1_r;
        wt_s3_r <= wt_s2_r;
        et_s1_r <= lnk.edge4_tgl;
        et_s2_r <= et_s1_r;
        et_s3_r <= et_s2_r;
        ck_s1_r <= PROG_CLK_I;
        ck_s2_r <= ck_s1_r;
    end

    logic word_evt;
    logic edge4_evt;
    logic [3:0] cmd;
    logic [15:0] payload;
    // word is stable for a whole frame after its toggle, so no copy is taken
    assign word_evt = wt_s2_r ^ wt_s3_r;
    assign edge4_evt = et_s2_r ^ et_s3_r;
    assign cmd = lnk.word[3:0];
    assign payload = lnk.word[19:4];

    scmwm_state_e state_r;
    scmwm_state_e state_nxt;
    logic [7:0] memctrl_r;
    logic [7:0] memctrl_nxt;
    logic [7:0] w_r;
    logic [7:0] w_nxt;
    logic [21:0] ptr_r;
    logic [21:0] ptr_nxt;
    logic op_erase_r;
    logic op_erase_nxt;
    logic [21:0] row_r;
    logic [21:0] row_nxt;
    logic [RW-1:0] idx_r;
    logic [RW-1:0] idx_nxt;
    logic done_r;
    logic done_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic fault_r;
    logic fault_nxt;
    logic link_en_r;
    logic link_en_nxt;
    logic [MW-1:0] maddr_r;
    logic [MW-1:0] maddr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;

    logic [7:0] wbuf [ROW_BYTES];
    logic [7:0] mem [MEM_BYTES];
    logic wb_we;
    logic [RW-1:0] wb_idx;
    logic mem_we;
    logic [MW-1:0] mem_addr;
    logic [7:0] mem_data;

    logic busy;
    logic code_sel;
    logic fault_set;
    logic apb_setup;
    logic apb_wr;
    logic mapped;
    logic [7:0] val;
    logic [2:0] bitn;

    assign busy = state_r != ST_IDLE;
    assign code_sel = memctrl_r[FLASH_SEL_BIT] & ~memctrl_r[CFG_SEL_BIT];
    assign apb_setup = PSEL_I & ~PENABLE_I;
    assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
    assign mapped = PADDR_I == REG_CTRL || PADDR_I == REG_STATUS || PADDR_I == REG_PTR
                    || PADDR_I == REG_MADDR || PADDR_I == REG_MDATA;
    // zero-wait slave: read data is registered in the setup cycle
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
    assign PRDATA_O = prdata_r;
    assign wb_idx = {ptr_r[RW-1:1], 1'b0};
    assign bitn = payload[11:9];
    assign val = (payload[15:8] == OP_MOVWF) ? w_r : 8'h00;

    always_comb begin
        state_nxt = state_r;
        memctrl_nxt = memctrl_r;
        w_nxt = w_r;
        ptr_nxt = ptr_r;
        op_erase_nxt = op_erase_r;
        row_nxt = row_r;
        idx_nxt = idx_r;
        done_nxt = done_r;
        cnt_nxt = cnt_r;
        fault_set = 1'b0;
        wb_we = 1'b0;
        mem_we = 1'b0;
        mem_addr = {row_r[MW-1:RW], idx_r};
        mem_data = op_erase_r ? ERASED_BYTE : wbuf[idx_r];
        if (word_evt && link_en_r) begin
            case (cmd)
                CMD_CORE: begin
                    if (payload[15:8] == OP_MOVLW) begin
                        w_nxt = payload[7:0];
                    end else if (payload[15:8] == OP_MOVWF || payload[15:8] == OP_CLRF) begin
                        case (payload[7:0])
                            ADDR_PTRU: ptr_nxt[21:16] = val[5:0];
                            ADDR_PTRH: ptr_nxt[15:8] = val;
                            ADDR_PTRL: ptr_nxt[7:0] = val;
                            default: ;
                        endcase
                    end else if ((payload[15:12] == OP_BSF || payload[15:12] == OP_BCF)
                                 && !payload[8] && payload[7:0] == ADDR_MEMCTRL) begin
                        if (32'(bitn) == WR_START_BIT) begin
                            // software cannot clear write-start, only hardware
                            if (payload[15:12] == OP_BSF && memctrl_r[WR_EN_BIT]
                                && code_sel && !busy) begin
                                memctrl_nxt[WR_START_BIT] = 1'b1;
                                state_nxt = ST_ARMED;
                                op_erase_nxt = memctrl_r[ROW_ERASE_BIT];
                                row_nxt = {ptr_r[21:RW], {RW{1'b0}}};
                            end
                        end else if (MEMCTRL_MASK[bitn]) begin
                            memctrl_nxt[bitn] = payload[15:12] == OP_BSF;
                        end
                    end
                end
                CMD_BUF_INC: begin
                    wb_we = 1'b1;
                    ptr_nxt = ptr_r + PTR_STEP;
                end
                CMD_BUF_PROG: begin
                    wb_we = 1'b1;
                    if (code_sel && !busy) begin
                        state_nxt = ST_ARMED;
                        op_erase_nxt = 1'b0;
                        row_nxt = {ptr_r[21:RW], {RW{1'b0}}};
                    end
                end
                default: ;
            endcase
        end
        case (state_r)
            ST_IDLE: ;
            ST_ARMED: begin
                if (edge4_evt) begin
                    state_nxt = ST_HOLD;
                    idx_nxt = '0;
                    done_nxt = 1'b0;
                    cnt_nxt = 16'h0000;
                end
            end
            ST_HOLD: begin
                // the array is rewritten while the link clock is held high
                if (!done_r) begin
                    mem_we = 1'b1;
                    idx_nxt = idx_r + RW'(1);
                    done_nxt = idx_r == RW'(ROW_BYTES - 1);
                end
                if (ck_s2_r && cnt_r != 16'hffff) begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
                if (!ck_s2_r && done_r) begin
                    memctrl_nxt[WR_START_BIT] = 1'b0;
                    fault_set = cnt_r < 16'(PROG_HOLD_CYC);
                    state_nxt = ST_DISCH;
                    cnt_nxt = 16'h0000;
                end
            end
            ST_DISCH: begin
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r >= DISCH_HOLD_CYC - 16'h0001) begin
                    state_nxt = ST_IDLE;
                end else if (ck_s2_r) begin
                    // clock rose before the array discharged
                    fault_set = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (!RST_N_I) begin
            state_nxt = ST_IDLE;
            memctrl_nxt = MEMCTRL_RST;
            w_nxt = 8'h00;
            ptr_nxt = 22'h000000;
            op_erase_nxt = 1'b0;
            row_nxt = 22'h000000;
            idx_nxt = '0;
            done_nxt = 1'b0;
            cnt_nxt = 16'h0000;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        state_r <= state_nxt;
        memctrl_r <= memctrl_nxt;
        w_r <= w_nxt;
        ptr_r <= ptr_nxt;
        op_erase_r <= op_erase_nxt;
        row_r <= row_nxt;
        idx_r <= idx_nxt;
        done_r <= done_nxt;
        cnt_r <= cnt_nxt;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            for (int i = 0; i < ROW_BYTES; i++) begin
                wbuf[i] <= ERASED_BYTE;
            end
        end else if (wb_we) begin
            wbuf[wb_idx] <= payload[7:0];
            wbuf[wb_idx | RW'(1)] <= payload[15:8];
        end
        if (mem_we) begin
            mem[mem_addr] <= mem_data;
        end
    end

    // apb registers
    always_comb begin
        link_en_nxt = link_en_r;
        maddr_nxt = maddr_r;
        prdata_nxt = prdata_r;
        // a timing fault raised in the clearing cycle survives
        fault_nxt = fault_r | fault_set;
        if (apb_wr && PADDR_I == REG_CTRL) begin
            link_en_nxt = PWDATA_I[CTRL_LINK_EN_BIT];
        end
        if (apb_wr && PADDR_I == REG_STATUS && PWDATA_I[STAT_FAULT_BIT]) begin
            fault_nxt = fault_set;
        end
        if (apb_wr && PADDR_I == REG_MADDR) begin
            maddr_nxt = PWDATA_I[MW-1:0];
        end
        if (apb_setup) begin
            case (PADDR_I)
                REG_CTRL: prdata_nxt = {31'h00000000, link_en_r};
                REG_STATUS: prdata_nxt = {22'h000000, fault_r, busy, memctrl_r};
                REG_PTR: prdata_nxt = {10'h000, ptr_r};
                REG_MADDR: prdata_nxt = 32'(maddr_r);
                REG_MDATA: prdata_nxt = {24'h000000, mem[maddr_r]};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
        if (!RST_N_I) begin
            link_en_nxt = CTRL_LINK_EN_RST;
            maddr_nxt = '0;
            prdata_nxt = 32'h00000000;
            fault_nxt = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        link_en_r <= link_en_nxt;
        maddr_r <= maddr_nxt;
        prdata_r <= prdata_nxt;
        fault_r <= fault_nxt;
    end

    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_core_word;
        word_evt && link_en_r && cmd == CMD_CORE;
    endsequence
    sequence s_hold_end;
        state_r == ST_HOLD ##1 state_r == ST_DISCH;
    endsequence

    core_bsf_a: assert property (s_core_word and payload == 16'h8ea6 |=>
        memctrl_r[FLASH_SEL_BIT]) else $error("flash select not set");
    ptr_step_a: assert property (word_evt && link_en_r && cmd == CMD_BUF_INC |=>
        ptr_r == $past(ptr_r) + PTR_STEP) else $error("pointer not advanced by two");
    no_start_a: assert property (word_evt && link_en_r && cmd == CMD_BUF_INC
        && state_r == ST_IDLE |=> state_r == ST_IDLE) else $error("buffer load started write");
    prog_arm_a: assert property (word_evt && link_en_r && cmd == CMD_BUF_PROG
        && code_sel && state_r == ST_IDLE |=> state_r == ST_ARMED && !op_erase_r)
        else $error("program command did not arm");
    wr_enable_a: assert property ($rose(memctrl_r[WR_START_BIT]) |->
        $past(memctrl_r[WR_EN_BIT])) else $error("write started without enable");
    erase_fill_a: assert property (state_r == ST_ARMED && op_erase_r ##1
        state_r == ST_HOLD |-> mem_we && mem_data == ERASED_BYTE) else $error("erase not done");
    buf_place_a: assert property (word_evt && link_en_r && cmd == CMD_BUF_INC |=>
        wbuf[$past(wb_idx)] == $past(payload[7:0])) else $error("byte at wrong slot");
    hold_start_a: assert property (state_r == ST_ARMED && edge4_evt |=>
        state_r == ST_HOLD [*8]) else $error("timed write did not start");
    wr_clear_a: assert property (s_hold_end |-> !memctrl_r[WR_START_BIT])
        else $error("write-start not cleared at end");
endmodule : scmwm_top
`default_nettype wire

//--- verilog/scmwm_pkg.sv
// constants shared by the serial code memory write/modify sequencer
// assumes a 20 MHz system clock and a programmer-driven link clock
package scmwm_pkg;
    localparam int CLK_PERIOD_NS = 50;
    // program_hold_time and discharge_hold_time minimums, microseconds
    localparam int PROG_HOLD_US = 1000;
    localparam int DISCH_HOLD_US = 5;
    localparam int PROG_HOLD_CYC_DFLT = (PROG_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] DISCH_HOLD_CYC =
        16'((DISCH_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // link framing: 4-bit command then 16-bit payload, lsb first
    localparam logic [4:0] FRAME_LAST = 5'h13;
    localparam logic [4:0] EDGE4_IDX = 5'h03;

    localparam logic [3:0] CMD_CORE = 4'h0;
    localparam logic [3:0] CMD_BUF_INC = 4'hd;
    localparam logic [3:0] CMD_BUF_PROG = 4'hf;

    localparam logic [7:0] OP_MOVLW = 8'h0e;
    localparam logic [7:0] OP_MOVWF = 8'h6e;
    localparam logic [7:0] OP_CLRF = 8'h6a;
    localparam logic [3:0] OP_BSF = 4'h8;
    localparam logic [3:0] OP_BCF = 4'h9;

    localparam logic [7:0] ADDR_MEMCTRL = 8'ha6;
    localparam logic [7:0] ADDR_PTRU = 8'hf8;
    localparam logic [7:0] ADDR_PTRH = 8'hf7;
    localparam logic [7:0] ADDR_PTRL = 8'hf6;

    // mem_ctrl_reg bits
    localparam int FLASH_SEL_BIT = 7;
    localparam int CFG_SEL_BIT = 6;
    localparam int ROW_ERASE_BIT = 4;
    localparam int WR_EN_BIT = 2;
    localparam int WR_START_BIT = 1;
    localparam logic [7:0] MEMCTRL_MASK = 8'hd6;
    localparam logic [7:0] MEMCTRL_RST = 8'h00;

    localparam logic [21:0] PTR_STEP = 22'h000002;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // apb map
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_PTR = 12'h008;
    localparam logic [11:0] REG_MADDR = 12'h00c;
    localparam logic [11:0] REG_MDATA = 12'h010;
    localparam int CTRL_LINK_EN_BIT = 0;
    localparam logic CTRL_LINK_EN_RST = 1'b1;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_FAULT_BIT = 9;

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_HOLD, ST_DISCH} scmwm_state_e;
endpackage : scmwm_pkg

//--- verilog/scmwm_link_if.sv
// carrier between the link receiver and the sequencer core
// assumes word is held stable while word_tgl crosses
`timescale 1ns/1ns
`default_nettype none
interface scmwm_link_if;
    logic [19:0] word;
    logic word_tgl;
    logic edge4_tgl;
    modport link_side (output word, output word_tgl, output edge4_tgl);
    modport core_side (input word, input word_tgl, input edge4_tgl);
endinterface : scmwm_link_if
`default_nettype wire

//--- verilog/scmwm_link_rx.sv
// link-clock side: shifts 20-bit frames and flags the 4th edge of each
// assumes reset is held across a few link clock edges
`timescale 1ns/1ns
`default_nettype none
module scmwm_link_rx
    import scmwm_pkg::*;
(
    input wire logic prog_clk_i,
    input wire logic rst_n_i,
    input wire logic prog_dat_i,
    scmwm_link_if.link_side lnk
);
    logic rst_s1_r;
    logic rst_s2_r;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [19:0] sh_r;
    logic [19:0] sh_nxt;
    logic [19:0] word_r;
    logic [19:0] word_nxt;
    logic wt_r;
    logic wt_nxt;
    logic et_r;
    logic et_nxt;

    always_comb begin
        cnt_nxt = cnt_r + 5'h01;
        sh_nxt = {prog_dat_i, sh_r[19:1]};
        word_nxt = word_r;
        wt_nxt = wt_r;
        et_nxt = et_r;
        if (cnt_r == EDGE4_IDX) begin
            et_nxt = ~et_r;
        end
        if (cnt_r == FRAME_LAST) begin
            word_nxt = sh_nxt;
            wt_nxt = ~wt_r;
            cnt_nxt = 5'h00;
        end
        if (!rst_s2_r) begin
            cnt_nxt = 5'h00;
            sh_nxt = 20'h00000;
            word_nxt = 20'h00000;
            wt_nxt = 1'b0;
            et_nxt = 1'b0;
        end
    end

    always_ff @(posedge prog_clk_i) begin
        rst_s1_r <= rst_n_i;
        rst_s2_r <= rst_s1_r;
        cnt_r <= cnt_nxt;
        sh_r <= sh_nxt;
        word_r <= word_nxt;
        wt_r <= wt_nxt;
        et_r <= et_nxt;
    end

    assign lnk.word = word_r;
    assign lnk.word_tgl = wt_r;
    assign lnk.edge4_tgl = et_r;
endmodule : scmwm_link_rx
`default_nettype wire

//--- test/scmwm_prog_model.sv
// programmer model: shifts 20-bit link frames, lsb first, on the link pins
// assumes one caller at a time; link clock stands low between frames
`timescale 1ns/1ns
`default_nettype none
module scmwm_prog_model (
    output logic prog_clk_o,
    output logic prog_dat_o
);
    initial begin
        prog_clk_o = 1'b0;
        prog_dat_o = 1'b0;
    end
    // free edges around reset; the link side drops the first two after release
    task automatic pulses(input int n);
        repeat (n) begin
            #15 prog_clk_o = 1'b1;
            #15 prog_clk_o = 1'b0;
        end
    endtask : pulses
    // hi_ns > 0 stretches the 4th edge of a nop into the timed write
    task automatic frame(input logic [19:0] w, input int hi_ns, input int lo_ns);
        for (int i = 0; i < 20; i++) begin
            prog_dat_o = w[i];
            #8 prog_clk_o = 1'b1;
            if (i == 3 && hi_ns > 0) begin
                #(hi_ns) prog_clk_o = 1'b0;
                #(lo_ns);
            end else begin
                #15 prog_clk_o = 1'b0;
                #7;
            end
        end
        // released line flips so a stale bit cannot pass for data
        prog_dat_o = ~prog_dat_o;
    endtask : frame
endmodule : scmwm_prog_model
`default_nettype wire

//--- test/test_scmwm_top.sv
// self-checking bench for the write/modify sequencer
// assumes the programmer model drives the link and apb reaches status
`timescale 1ns/1ns
`default_nettype none
module test_scmwm_top;
    import scmwm_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pclk;
    logic pdat;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    int num_errors = 0;
    int tests_run = 0;

    always #25 clk = ~clk;

    scmwm_prog_model prog_u (.prog_clk_o(pclk), .prog_dat_o(pdat));
    // short hold keeps the run brief; the nop still holds far longer
    scmwm_top #(.ROW_BYTES(64), .MEM_BYTES(1024), .PROG_HOLD_CYC(20)) dut_u (
        .SYS_CLK_I(clk), .RST_N_I(rst_n), .PROG_CLK_I(pclk), .PROG_DAT_I(pdat),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr)
    );

    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // no wait count is assumed; only the watchdog ends a stuck access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask : rd

    task automatic send(input logic [3:0] c, input logic [15:0] p);
        prog_u.frame({p, c}, 0, 0);
        repeat (8) @(posedge clk);
    endtask : send

    // hold well past the 64-cycle commit, discharge past 100 cycles
    task automatic nop();
        prog_u.frame(20'h00000, 5000, 6000);
        repeat (8) @(posedge clk);
    endtask : nop

    task automatic set_ptr(input logic [21:0] a);
        send(CMD_CORE, {OP_MOVLW, 2'b00, a[21:16]});
        send(CMD_CORE, {OP_MOVWF, ADDR_PTRU});
        send(CMD_CORE, {OP_MOVLW, a[15:8]});
        send(CMD_CORE, {OP_MOVWF, ADDR_PTRH});
        send(CMD_CORE, {OP_MOVLW, a[7:0]});
        send(CMD_CORE, {OP_MOVWF, ADDR_PTRL});
    endtask : set_ptr

    task automatic mem(input logic [9:0] a, input logic [7:0] exp);
        wr(REG_MADDR, {22'h0, a});
        rd(REG_MDATA, {24'h0, exp});
    endtask : mem

    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rd(REG_CTRL, 32'h00000001);
        rd(REG_STATUS, 32'h00000000);
        rd(REG_PTR, 32'h00000000);
        apb(1'b0, 12'h0ff, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        wr(REG_MADDR, 32'h00000155);
        rd(REG_MADDR, 32'h00000155);
    endtask : t_reset

    task automatic t_select();
        send(CMD_CORE, 16'h8ea6);
        send(CMD_CORE, 16'h9ca6);
        rd(REG_STATUS, 32'h00000080);
        set_ptr(22'h010340);
        rd(REG_PTR, 32'h00010340);
    endtask : t_select

    task automatic t_gate();
        wr(REG_CTRL, 32'h0);
        send(CMD_CORE, 16'h84a6);
        rd(REG_STATUS, 32'h00000080);
        wr(REG_CTRL, 32'h1);
        send(CMD_CORE, 16'h82a6);
        rd(REG_STATUS, 32'h00000080);
    endtask : t_gate

    task automatic t_program();
        send(CMD_BUF_INC, 16'h1234);
        rd(REG_PTR, 32'h00010342);
        send(CMD_BUF_PROG, 16'h5678);
        rd(REG_STATUS, 32'h00000180);
        rd(REG_PTR, 32'h00010342);
        nop();
        rd(REG_STATUS, 32'h00000080);
        mem(10'h340, 8'h34);
        mem(10'h341, 8'h12);
        mem(10'h342, 8'h78);
        mem(10'h343, 8'h56);
        mem(10'h344, 8'hff);
    endtask : t_program

    task automatic t_modify();
        send(CMD_CORE, 16'h84a6);
        set_ptr(22'h010355);
        mem(10'h342, 8'h78);
        send(CMD_CORE, 16'h88a6);
        send(CMD_CORE, 16'h82a6);
        rd(REG_STATUS, 32'h00000196);
        nop();
        rd(REG_STATUS, 32'h00000094);
        mem(10'h340, 8'hff);
        mem(10'h343, 8'hff);
        send(CMD_CORE, 16'h98a6);
        set_ptr(22'h010340);
        send(CMD_BUF_INC, 16'hbeef);
        send(CMD_BUF_PROG, 16'hcafe);
        nop();
        mem(10'h340, 8'hef);
        mem(10'h341, 8'hbe);
        mem(10'h342, 8'hfe);
        mem(10'h343, 8'hca);
        mem(10'h344, 8'hff);
        send(CMD_CORE, 16'h94a6);
        rd(REG_STATUS, 32'h00000080);
    endtask : t_modify

    // a hold shorter than the program time must raise the timing fault
    task automatic t_fault();
        send(CMD_BUF_PROG, 16'h0000);
        rd(REG_STATUS, 32'h00000180);
        prog_u.frame(20'h00000, 300, 9000);
        repeat (8) @(posedge clk);
        rd(REG_STATUS, 32'h00000280);
        wr(REG_STATUS, 32'h00000200);
        rd(REG_STATUS, 32'h00000080);
    endtask : t_fault

    initial begin
        fork
            prog_u.pulses(8);
            repeat (6) @(posedge clk);
        join
        rst_n <= 1'b1;
        // the link side discards two edges while its reset copy releases
        prog_u.pulses(2);
        repeat (4) @(posedge clk);
        t_reset();
        t_select();
        t_gate();
        t_program();
        t_modify();
        t_fault();
        report_and_stop();
    end

    // whole run needs well under 300 us
    initial begin
        #2000000;
        num_errors++;
        report_and_stop();
    end
endmodule : test_scmwm_top
`default_nettype wire
